// File: design/gpint_top.sv
`timescale 1ns/1ps
// Operation
// - direction bit 0 makes pin input, 1 output; reset zero
// - alternate-function pins ignore direction, set and clear controls
// - set port: ones drive outputs high, zeros leave unchanged
// - clear port: ones drive outputs low, zeros leave unchanged
// - set and clear do nothing to input pins
// - level register reads present level of all ten pins
// - writing level register sets ones and clears zeros on outputs
// - unmasked input change makes a packet; mask resets to 0x100
// - masking applies to all inputs, general or alternate
// - masked pins still show level in reads and packets
// - break enable bit lets a received break cause a packet
// - format bit picks standard (0) or customized (1) packet
// - standard header: a1, 20, zero value and index, length 2
// - standard data: overrun D6 down to carrier detect D0
// - overrun reported when receive characters were discarded
// - custom packet: pin levels then pin change bits, low byte first
// - custom status byte: overrun, parity, framing, break in bits 3..0
// - three-bit mode field hands handshake pins to alternate functions
module gpint_top
	import gpint_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic CE,
	// axi4-lite slave
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// pins
	input wire logic [GPINT_NPINS-1:0] PIN_IN,
	output logic [GPINT_NPINS-1:0] PIN_OUT,
	output logic [GPINT_NPINS-1:0] PIN_OE,
	// alternate-function drive from the uart
	input wire logic [GPINT_NPINS-1:0] ALT_OUT,
	input wire logic [GPINT_NPINS-1:0] ALT_OE,
	// uart status events, same clock
	input wire gpint_uart_t UART_STATUS,
	input wire logic UART_ERR_EVENT,
	input wire logic UART_BREAK_EVENT,
	// interrupt packet byte stream
	output gpint_byte_t PKT_BYTE,
	output logic PKT_VALID,
	input wire logic PKT_READY,
	// pin mode field visible to the uart
	output logic [15:0] PIN_MODE
);
	////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {GPINT_IDLE, GPINT_SEND} gpint_state_t;

	logic [GPINT_NPINS-1:0] sync1_reg, sync2_reg, prev_reg;
	logic [GPINT_NPINS-1:0] dir_reg, out_reg, mask_reg, chg_reg, snap_chg_reg, snap_lvl_reg;
	logic [1:0] fmt_reg;
	logic [15:0] mode_reg;
	logic [6:0] snap_uart_reg;
	logic aw_reg, w_reg, bvalid_reg, rvalid_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg, rdata_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic pend_reg;
	logic [3:0] cnt_reg;
	gpint_state_t state_reg;

	////////////////////////////////////////////////////////////////
	// alternate-function ownership per pin
	wire [2:0] mode_sel = mode_reg[2:0];
	wire rs485_on_7 = mode_reg[4];
	wire [GPINT_NPINS-1:0] alt_map;
	assign alt_map[1:0] = 2'h0;
	assign alt_map[3:2] = (mode_sel == GPINT_MODE_DTRDSR) ? 2'h3 : 2'h0;
	assign alt_map[4] = (mode_sel == GPINT_MODE_RTSCTS);
	assign alt_map[5] = (mode_sel == GPINT_MODE_RTSCTS) ||
		(!rs485_on_7 && (mode_sel == GPINT_MODE_RS485A || mode_sel == GPINT_MODE_RS485F));
	assign alt_map[6] = mode_reg[7];
	assign alt_map[7] = rs485_on_7 && (mode_reg[6:5] != 2'h0);
	assign alt_map[9:8] = mode_reg[9:8];
	wire [GPINT_NPINS-1:0] gp_out = ~alt_map & dir_reg;
	wire [GPINT_NPINS-1:0] in_dir = (alt_map & ~ALT_OE) | (~alt_map & ~dir_reg);

	assign PIN_OE = (alt_map & ALT_OE) | gp_out;
	assign PIN_OUT = (alt_map & ALT_OUT) | (~alt_map & out_reg);
	assign PIN_MODE = mode_reg;

	////////////////////////////////////////////////////////////////
	// axi4-lite write path
	wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_hs = S_AXI_WVALID && S_AXI_WREADY;
	wire [7:0] wa_cur = aw_reg ? awaddr_reg : S_AXI_AWADDR;
	wire [31:0] wd_cur = w_reg ? wdata_reg : S_AXI_WDATA;
	wire have_aw = aw_reg || aw_hs;
	wire have_w = w_reg || w_hs;
	wire do_wr = have_aw && have_w && !bvalid_reg;
	wire [7:0] w_idx = {2'h0, wa_cur[7:2]};
	wire w_lo = S_AXI_WSTRB[0] || w_reg;
	wire w_ok = (w_idx >= GPINT_IDX_MODE) && (w_idx <= GPINT_IDX_FMT);
	wire wr_mode = do_wr && w_lo && w_idx == GPINT_IDX_MODE;
	wire wr_dir = do_wr && w_lo && w_idx == GPINT_IDX_DIR;
	wire wr_set = do_wr && w_lo && w_idx == GPINT_IDX_SET;
	wire wr_clr = do_wr && w_lo && w_idx == GPINT_IDX_CLR;
	wire wr_lvl = do_wr && w_lo && w_idx == GPINT_IDX_LEVEL;
	wire wr_mask = do_wr && w_lo && w_idx == GPINT_IDX_MASK;
	wire wr_fmt = do_wr && w_lo && w_idx == GPINT_IDX_FMT;
	wire [GPINT_NPINS-1:0] wbits = wd_cur[GPINT_NPINS-1:0]; // upper bits dropped
	wire [GPINT_NPINS-1:0] gp_ctl = ~alt_map & dir_reg;
	wire [GPINT_NPINS-1:0] out_set = wr_set ? (wbits & gp_ctl) : '0;
	wire [GPINT_NPINS-1:0] out_clr = wr_clr ? (wbits & gp_ctl) : '0;
	wire [GPINT_NPINS-1:0] out_lvl = wr_lvl ? gp_ctl : '0;
	wire [GPINT_NPINS-1:0] out_next = (out_reg & ~out_lvl & ~out_clr) | (wbits & out_lvl) | out_set;

	assign S_AXI_AWREADY = !aw_reg && !bvalid_reg;
	assign S_AXI_WREADY = !w_reg && !bvalid_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;

	////////////////////////////////////////////////////////////////
	// axi4-lite read path
	wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
	wire [7:0] r_idx = {2'h0, S_AXI_ARADDR[7:2]};
	wire [GPINT_NPINS-1:0] pad10 = '0;
	wire [31:0] rd_mux =
		(r_idx == GPINT_IDX_MODE) ? {16'h0, mode_reg} :
		(r_idx == GPINT_IDX_DIR) ? {22'h0, dir_reg} :
		(r_idx == GPINT_IDX_LEVEL) ? {22'h0, sync2_reg} :
		(r_idx == GPINT_IDX_MASK) ? {22'h0, mask_reg} :
		(r_idx == GPINT_IDX_FMT) ? {30'h0, fmt_reg} :
		{22'h0, pad10}; // write-only ports read zero
	wire r_ok = (r_idx >= GPINT_IDX_MODE) && (r_idx <= GPINT_IDX_FMT);
	assign S_AXI_ARREADY = !rvalid_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;

	////////////////////////////////////////////////////////////////
	// change detection and trigger
	wire [GPINT_NPINS-1:0] edges = (sync2_reg ^ prev_reg) & in_dir & ~mask_reg;
	wire brk_trig = UART_BREAK_EVENT && fmt_reg[GPINT_FMT_BRKEN_BIT];
	wire trig = (|edges) || brk_trig || UART_ERR_EVENT;
	wire start = (state_reg == GPINT_IDLE) && (pend_reg || trig);
	wire pkt_take = PKT_VALID && PKT_READY;
	wire custom = fmt_reg[GPINT_FMT_CUSTOM_BIT];
	wire [3:0] last_idx = custom ? 4'h4 : 4'(GPINT_PKT_BYTES - 1);
	wire [6:0] u = UART_STATUS; // overrun bit passed through from receive path
	wire [15:0] std_data = {9'h0, snap_uart_reg};
	wire [7:0] cust_stat = {4'h0, snap_uart_reg[6], snap_uart_reg[5], snap_uart_reg[4], snap_uart_reg[2]};
	wire [15:0] lvl16 = {6'h0, snap_lvl_reg};
	wire [15:0] chg16 = {6'h0, snap_chg_reg};
	logic [7:0] byte_sel;
	always_comb begin
		byte_sel = 8'h00;
		if (custom) begin
			case (cnt_reg)
				4'h0: byte_sel = lvl16[7:0];
				4'h1: byte_sel = lvl16[15:8];
				4'h2: byte_sel = chg16[7:0];
				4'h3: byte_sel = chg16[15:8];
				4'h4: byte_sel = cust_stat;
				default: byte_sel = 8'h00;
			endcase
		end else begin
			case (cnt_reg)
				4'h0: byte_sel = GPINT_REQ_TYPE;
				4'h1: byte_sel = GPINT_NOTIF;
				4'h6: byte_sel = GPINT_WLEN[7:0];
				4'h7: byte_sel = GPINT_WLEN[15:8];
				4'h8: byte_sel = std_data[7:0];
				4'h9: byte_sel = std_data[15:8];
				default: byte_sel = 8'h00;
			endcase
		end
	end
	assign PKT_VALID = (state_reg == GPINT_SEND);
	// byte for the beat on offer: selected from the snapshot registers, so it stands until taken
	assign PKT_BYTE = '{data: byte_sel, last: (cnt_reg == last_idx)};

	////////////////////////////////////////////////////////////////
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg <= '0;
			dir_reg <= GPINT_RST_DIR[GPINT_NPINS-1:0];
			out_reg <= '0;
			mask_reg <= GPINT_RST_MASK[GPINT_NPINS-1:0];
			fmt_reg <= GPINT_RST_FMT[1:0];
			mode_reg <= GPINT_RST_MODE;
			aw_reg <= 1'b0;
			w_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= 2'h0;
		end else if (CE) begin
			sync1_reg <= PIN_IN;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
			out_reg <= out_next;
			if (wr_dir) dir_reg <= wbits;
			if (wr_mask) mask_reg <= wbits;
			if (wr_fmt) fmt_reg <= wd_cur[1:0];
			if (wr_mode) mode_reg <= {6'h0, wd_cur[9:0]};
			if (aw_hs && !do_wr) begin
				aw_reg <= 1'b1;
				awaddr_reg <= S_AXI_AWADDR;
			end else if (do_wr) aw_reg <= 1'b0;
			if (w_hs && !do_wr) begin
				w_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA;
			end else if (do_wr) w_reg <= 1'b0;
			if (do_wr) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= w_ok ? 2'h0 : 2'h2;
			end else if (S_AXI_BREADY) bvalid_reg <= 1'b0;
			if (ar_hs) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_mux;
				rresp_reg <= r_ok ? 2'h0 : 2'h2;
			end else if (S_AXI_RREADY) rvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			state_reg <= GPINT_IDLE;
			chg_reg <= '0;
			snap_chg_reg <= '0;
			snap_lvl_reg <= '0;
			snap_uart_reg <= 7'h0;
			pend_reg <= 1'b0;
			cnt_reg <= 4'h0;
		end else if (CE) begin
			case (state_reg)
				GPINT_IDLE: begin
					if (start) begin
						snap_chg_reg <= chg_reg | edges;
						chg_reg <= '0;
						snap_lvl_reg <= sync2_reg;
						snap_uart_reg <= u;
						pend_reg <= 1'b0;
						cnt_reg <= 4'h0;
						state_reg <= GPINT_SEND;
					end
				end
				GPINT_SEND: begin
					chg_reg <= chg_reg | edges;
					if (trig) pend_reg <= 1'b1; // a trigger during a packet is not lost
					if (pkt_take) begin
						if (cnt_reg == last_idx) state_reg <= GPINT_IDLE;
						else cnt_reg <= cnt_reg + 4'h1;
					end
				end
				default: state_reg <= GPINT_IDLE;
			endcase
		end
	end
endmodule

// File: design/gpint_pkg.sv
package gpint_pkg;
	localparam int GPINT_NPINS = 10;
	// printed offsets are register indices; byte address is four times the index
	localparam logic [7:0] GPINT_IDX_MODE = 8'h0c;
	localparam logic [7:0] GPINT_IDX_DIR = 8'h0d;
	localparam logic [7:0] GPINT_IDX_SET = 8'h0e;
	localparam logic [7:0] GPINT_IDX_CLR = 8'h0f;
	localparam logic [7:0] GPINT_IDX_LEVEL = 8'h10;
	localparam logic [7:0] GPINT_IDX_MASK = 8'h11;
	localparam logic [7:0] GPINT_IDX_FMT = 8'h12;
	localparam logic [7:0] GPINT_IDX_UART = 8'h20;
	localparam logic [15:0] GPINT_RST_DIR = 16'h0000;
	localparam logic [15:0] GPINT_RST_MASK = 16'h0100;
	localparam logic [15:0] GPINT_RST_FMT = 16'h0000;
	localparam logic [15:0] GPINT_RST_MODE = 16'h0300;
	localparam int GPINT_FMT_CUSTOM_BIT = 0;
	localparam int GPINT_FMT_BRKEN_BIT = 1;
	localparam logic [7:0] GPINT_REQ_TYPE = 8'ha1;
	localparam logic [7:0] GPINT_NOTIF = 8'h20;
	localparam logic [15:0] GPINT_WLEN = 16'h0002;
	localparam int GPINT_PKT_BYTES = 10;
	// pin mode field codes
	localparam logic [2:0] GPINT_MODE_GPIO = 3'h0;
	localparam logic [2:0] GPINT_MODE_RTSCTS = 3'h1;
	localparam logic [2:0] GPINT_MODE_DTRDSR = 3'h2;
	localparam logic [2:0] GPINT_MODE_RS485A = 3'h3;
	localparam logic [2:0] GPINT_MODE_RS485F = 3'h4;
	typedef struct packed {
		logic overrun;
		logic parity;
		logic framing;
		logic ring;
		logic brk;
		logic dsr;
		logic cd;
	} gpint_uart_t;
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} gpint_byte_t;
endpackage

// File: dv/gpint_sva.sv
`timescale 1ns/1ps
module gpint_sva (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_B,
	// register bus
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// pins, uart and packet
	input wire logic [9:0] PIN_IN,
	input wire logic [9:0] PIN_OE,
	input wire logic [9:0] ALT_OE,
	input wire logic UART_ERR_EVENT,
	input wire gpint_pkg::gpint_byte_t PKT_BYTE,
	input wire logic PKT_VALID,
	input wire logic PKT_READY,
	input wire logic [15:0] PIN_MODE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	////////////////////////////////////////
	a_reset_state: assert property ($rose(RST_B) |-> PIN_OE[7:0] == 8'h00 && PIN_MODE == 16'h0300)
		else $error("pins not idle after reset");
	a_alt_pins: assert property (PIN_MODE[9:8] == 2'h3 |-> PIN_OE[9:8] == ALT_OE[9:8])
		else $error("alternate pins not under uart drive");
	a_bvalid_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response withdrawn");
	a_rvalid_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read response withdrawn");
	a_unmapped_err: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h00 |=> S_AXI_RRESP == 2'h2)
		else $error("unmapped read not refused");
	a_level_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h40 && $past(RST_B, 3)
		&& $stable(PIN_IN) && PIN_IN == $past(PIN_IN, 3) |=> S_AXI_RDATA == {22'h0, $past(PIN_IN)})
		else $error("level read differs from pins");
	a_pkt_holds: assert property (PKT_VALID && !PKT_READY |=> PKT_VALID && $stable(PKT_BYTE))
		else $error("packet byte moved before taken");
	a_err_packet: assert property ($rose(UART_ERR_EVENT) && !PKT_VALID |-> ##[1:3] PKT_VALID)
		else $error("error event made no packet");
endmodule
bind gpint_top gpint_sva u_sva (.CLOCK, .RST_B, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
	.S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_BVALID, .S_AXI_BREADY, .PIN_IN, .PIN_OE, .ALT_OE,
	.UART_ERR_EVENT, .PKT_BYTE, .PKT_VALID, .PKT_READY, .PIN_MODE);

// File: dv/gpint_far.sv
`timescale 1ns/1ps
module gpint_far (
	// clock
	input wire logic clock,
	// pins and packet sink
	input wire logic [9:0] pin_out,
	input wire logic [9:0] pin_oe,
	input wire logic [9:0] ext_level,
	input wire logic slow,
	output logic [9:0] pin_in,
	output logic pkt_ready
);
	logic phase_reg = 1'h0;
	////////////////////////////////////////
	// far devices drive every pin the block leaves undriven
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
	always_ff @(posedge clock) begin
		phase_reg <= ~phase_reg;
	end
	// a slow host takes a byte only every other cycle
	assign pkt_ready = !slow || phase_reg;
endmodule

// File: dv/gpint_top_test.sv
`timescale 1ns/1ps
module gpint_top_test;
	import gpint_pkg::*;
	logic CLOCK = 1'h0, RST_B = 1'h0, CE = 1'h1, slow = 1'h0;
	logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0, S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, PKT_VALID, PKT_READY;
	logic UART_ERR_EVENT = 1'h0, UART_BREAK_EVENT = 1'h0;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB = 4'hf;
	logic [9:0] PIN_IN, PIN_OUT, PIN_OE, ext = 10'h000, ALT_OUT = 10'h000, ALT_OE = 10'h000;
	logic [15:0] PIN_MODE;
	gpint_uart_t UART_STATUS = 7'h00;
	gpint_byte_t PKT_BYTE;
	int n_errors = 0, checks_done = 0;
	gpint_top dut (.CLOCK, .RST_B, .CE, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
		.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
		.S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .PIN_IN, .PIN_OUT, .PIN_OE,
		.ALT_OUT, .ALT_OE, .UART_STATUS, .UART_ERR_EVENT, .UART_BREAK_EVENT, .PKT_BYTE, .PKT_VALID, .PKT_READY,
		.PIN_MODE);
	gpint_far far (.clock(CLOCK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext_level(ext), .slow, .pin_in(PIN_IN),
		.pkt_ready(PKT_READY));
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one bus access; a read compares data only when no error is expected
	task automatic acc(input logic wr, input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
		logic [31:0] rd;
		logic [1:0] rsp;
		int t;
		t = 0;
		S_AXI_AWADDR <= {idx[5:0], 2'h0};
		S_AXI_ARADDR <= {idx[5:0], 2'h0};
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= wr;
		S_AXI_WVALID <= wr;
		S_AXI_BREADY <= wr;
		S_AXI_ARVALID <= !wr;
		S_AXI_RREADY <= !wr;
		do begin
			@(posedge CLOCK);
			t++;
			if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
			if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
			if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
			rsp = wr ? S_AXI_BRESP : S_AXI_RRESP;
			rd = S_AXI_RDATA;
		end while ((wr ? S_AXI_BVALID : S_AXI_RVALID) !== 1'h1 && t < 50);
		S_AXI_BREADY <= 1'h0;
		S_AXI_RREADY <= 1'h0;
		// one idle edge between accesses; also lets the pin synchroniser settle
		@(posedge CLOCK);
		chk(t < 50, 1);
		chk(rsp, er);
		if (!wr && er == 2'h0) chk(rd, d);
	endtask
	task automatic pkt(input logic [7:0] e []);
		int k, t;
		k = 0;
		t = 0;
		while (k < e.size() && t < 200) begin
			@(posedge CLOCK);
			t++;
			if (PKT_VALID === 1'h1 && PKT_READY) begin
				chk(PKT_BYTE.data, e[k]);
				k++;
			end
		end
		chk(k, e.size());
	endtask
	task automatic quiet();
		int c;
		c = 0;
		repeat (30) begin
			@(posedge CLOCK);
			if (PKT_VALID !== 1'h0) c++;
		end
		chk(c, 0);
	endtask
	task automatic event_pulse(input logic brk);
		UART_BREAK_EVENT <= brk;
		UART_ERR_EVENT <= !brk;
		@(posedge CLOCK);
		UART_BREAK_EVENT <= 1'h0;
		UART_ERR_EVENT <= 1'h0;
	endtask
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		forever #5 CLOCK = ~CLOCK;
	end
	initial begin
		repeat (5000) @(posedge CLOCK);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge CLOCK);
		RST_B <= 1'h1;
		@(posedge CLOCK);
		acc(0, GPINT_IDX_DIR, 32'h0, 2'h0);
		acc(0, GPINT_IDX_MASK, 32'h100, 2'h0);
		acc(0, GPINT_IDX_FMT, 32'h0, 2'h0);
		acc(0, GPINT_IDX_LEVEL, 32'h0, 2'h0);
		acc(0, GPINT_IDX_MODE, 32'h300, 2'h0);
		acc(0, 8'h00, 32'h0, 2'h2);
		acc(1, GPINT_IDX_DIR, 32'h0f7, 2'h0);
		acc(0, GPINT_IDX_DIR, 32'h0f7, 2'h0);
		acc(1, GPINT_IDX_SET, 32'h3ff, 2'h0);
		acc(0, GPINT_IDX_LEVEL, 32'h0f7, 2'h0);
		acc(1, GPINT_IDX_DIR, 32'h0ff, 2'h0);
		acc(0, GPINT_IDX_LEVEL, 32'h0f7, 2'h0);
		acc(1, GPINT_IDX_CLR, 32'h3c3, 2'h0);
		acc(0, GPINT_IDX_LEVEL, 32'h034, 2'h0);
		acc(1, GPINT_IDX_LEVEL, 32'h0f0, 2'h0);
		acc(0, GPINT_IDX_LEVEL, 32'h0f0, 2'h0);
		UART_STATUS <= 7'h50;
		event_pulse(0);
		pkt('{8'ha1, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h50, 8'h00});
		UART_STATUS <= 7'h04;
		event_pulse(1);
		quiet();
		acc(1, GPINT_IDX_FMT, 32'h3, 2'h0);
		slow <= 1'h1;
		event_pulse(1);
		pkt('{8'hf0, 8'h00, 8'h00, 8'h00, 8'h01});
		UART_STATUS <= 7'h00;
		ext <= 10'h100;
		quiet();
		acc(0, GPINT_IDX_LEVEL, 32'h1f0, 2'h0);
		ext <= 10'h300;
		pkt('{8'hf0, 8'h03, 8'h00, 8'h02, 8'h00});
		acc(1, GPINT_IDX_MODE, 32'h301, 2'h0);
		pkt('{8'hc0, 8'h03, 8'h30, 8'h00, 8'h00});
		tally_and_finish();
	end
endmodule
